// *** rtl/dplt_pkg.sv ***
// Package of constants and types for the PHY control and line-trap registers.
// Assumes a 32-bit AXI4-Lite register port and a single 100 MHz clock.
package dplt_pkg;
   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] PHY_RESET_CONTROL_OFF = 8'h00;
   localparam logic [7:0] IRQ_RAW_STATUS_OFF = 8'h04;
   localparam logic [7:0] IRQ_MASKED_STATUS_OFF = 8'h08;
   localparam logic [7:0] IRQ_ENABLE_SET_OFF = 8'h0C;
   localparam logic [7:0] IRQ_ENABLE_CLEAR_OFF = 8'h10;
   localparam logic [7:0] PHY_CONTROL_ONE_OFF = 8'h14;
   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int PHY_RESET_REQUEST_BIT = 10;
   localparam logic [31:0] PHY_RESET_CONTROL_RST = 32'h0000_2091;
   localparam int LINE_TRAP_BIT = 2;
   localparam int DLL_MODE_LSB = 12;
   localparam int STROBE_GATING_BIT = 7;
   localparam int RX_POWERDOWN_BIT = 6;
   localparam int READ_LATENCY_LSB = 0;
   localparam logic [2:0] DLL_MODE_RST = 3'h0;
   localparam logic STROBE_GATING_RST = 1'b0;
   localparam logic RX_POWERDOWN_RST = 1'b1;
   localparam logic [2:0] READ_LATENCY_RST = 3'h6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [2:0] dll_mode;
      logic strobe_gating_select;
      logic receiver_idle_powerdown;
      logic [2:0] read_latency;
   } dplt_phy_cfg_t;
endpackage

// *** rtl/dplt_regs.sv ***
// Register bank: PHY reset request, line-trap interrupt, PHY control.
// Assumes an AXI4-Lite master on aclk and a line-trap pulse on aclk.
`timescale 1ns/1ps
`default_nettype none

module dplt_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_trap_event,
   output logic phy_reset_request,
   output dplt_pkg::dplt_phy_cfg_t phy_cfg,
   output logic irq
);
   // ****************************************************************
   // Write channel
   // ****************************************************************
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_fire;
   logic wr_ok;

   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   function automatic logic known(input logic [7:0] a);
      known = (a == dplt_pkg::PHY_RESET_CONTROL_OFF) ||
              (a == dplt_pkg::IRQ_RAW_STATUS_OFF) ||
              (a == dplt_pkg::IRQ_MASKED_STATUS_OFF) ||
              (a == dplt_pkg::IRQ_ENABLE_SET_OFF) ||
              (a == dplt_pkg::IRQ_ENABLE_CLEAR_OFF) ||
              (a == dplt_pkg::PHY_CONTROL_ONE_OFF);
   endfunction

   assign wr_ok = known(awaddr_reg);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dplt_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? dplt_pkg::RESP_OKAY : dplt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // One-hot write strobes, gated by the byte lane holding each field.
   function automatic logic wbit(input logic [7:0] off, input int b);
      wbit = wr_fire && (awaddr_reg == off) && wstrb_reg[b / 8] &&
             wdata_reg[b];
   endfunction

   // ****************************************************************
   // Line-trap status and enable
   // ****************************************************************
   logic line_trap_raw_reg;
   logic line_trap_masked_reg;
   logic line_trap_enable_reg;
   logic clr_trap;
   logic en_set;
   logic en_clr;

   // A process, not a continuous assignment: the strobe function reads the
   // held write state directly, so the strobes must follow that state.
   always_comb begin
      clr_trap = wbit(dplt_pkg::IRQ_RAW_STATUS_OFF,
                      dplt_pkg::LINE_TRAP_BIT) ||
                 wbit(dplt_pkg::IRQ_MASKED_STATUS_OFF,
                      dplt_pkg::LINE_TRAP_BIT);
      en_set = wbit(dplt_pkg::IRQ_ENABLE_SET_OFF,
                    dplt_pkg::LINE_TRAP_BIT);
      en_clr = wbit(dplt_pkg::IRQ_ENABLE_CLEAR_OFF,
                    dplt_pkg::LINE_TRAP_BIT);
   end

   // A trap arriving in the clearing cycle wins, so no event is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_trap_raw_reg <= 1'b0;
         line_trap_masked_reg <= 1'b0;
      end else begin
         if (line_trap_event) begin
            line_trap_raw_reg <= 1'b1;
         end else if (clr_trap) begin
            line_trap_raw_reg <= 1'b0;
         end
         if (line_trap_event && line_trap_enable_reg) begin
            line_trap_masked_reg <= 1'b1;
         end else if (clr_trap) begin
            line_trap_masked_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_trap_enable_reg <= 1'b0;
      end else if (en_set && en_clr) begin
         line_trap_enable_reg <= 1'b0;
      end else if (en_set) begin
         line_trap_enable_reg <= 1'b1;
      end else if (en_clr) begin
         line_trap_enable_reg <= 1'b0;
      end
   end

   assign irq = line_trap_masked_reg;

   // ****************************************************************
   // PHY reset and PHY control
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phy_reset_request <= 1'b0;
      end else begin
         phy_reset_request <= wbit(dplt_pkg::PHY_RESET_CONTROL_OFF,
                                   dplt_pkg::PHY_RESET_REQUEST_BIT);
      end
   end

   logic cfg_wr;
   assign cfg_wr = wr_fire && (awaddr_reg == dplt_pkg::PHY_CONTROL_ONE_OFF);

   // Read latency is passed as a count of controller clocks; a value
   // outside the supported window is stored unchanged.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phy_cfg.dll_mode <= dplt_pkg::DLL_MODE_RST;
         phy_cfg.strobe_gating_select <= dplt_pkg::STROBE_GATING_RST;
         phy_cfg.receiver_idle_powerdown <= dplt_pkg::RX_POWERDOWN_RST;
         phy_cfg.read_latency <= dplt_pkg::READ_LATENCY_RST;
      end else if (cfg_wr) begin
         if (wstrb_reg[1]) begin
            phy_cfg.dll_mode <=
               wdata_reg[dplt_pkg::DLL_MODE_LSB +: 3];
         end
         if (wstrb_reg[0]) begin
            phy_cfg.strobe_gating_select <=
               wdata_reg[dplt_pkg::STROBE_GATING_BIT];
            phy_cfg.receiver_idle_powerdown <=
               wdata_reg[dplt_pkg::RX_POWERDOWN_BIT];
            phy_cfg.read_latency <=
               wdata_reg[dplt_pkg::READ_LATENCY_LSB +: 3];
         end
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         dplt_pkg::PHY_RESET_CONTROL_OFF:
            rd_word = dplt_pkg::PHY_RESET_CONTROL_RST;
         dplt_pkg::IRQ_RAW_STATUS_OFF:
            rd_word[dplt_pkg::LINE_TRAP_BIT] = line_trap_raw_reg;
         dplt_pkg::IRQ_MASKED_STATUS_OFF:
            rd_word[dplt_pkg::LINE_TRAP_BIT] = line_trap_masked_reg;
         dplt_pkg::IRQ_ENABLE_SET_OFF:
            rd_word[dplt_pkg::LINE_TRAP_BIT] = line_trap_enable_reg;
         dplt_pkg::IRQ_ENABLE_CLEAR_OFF:
            rd_word[dplt_pkg::LINE_TRAP_BIT] = line_trap_enable_reg;
         dplt_pkg::PHY_CONTROL_ONE_OFF: begin
            rd_word[dplt_pkg::DLL_MODE_LSB +: 3] = phy_cfg.dll_mode;
            rd_word[dplt_pkg::STROBE_GATING_BIT] =
               phy_cfg.strobe_gating_select;
            rd_word[dplt_pkg::RX_POWERDOWN_BIT] =
               phy_cfg.receiver_idle_powerdown;
            rd_word[dplt_pkg::READ_LATENCY_LSB +: 3] = phy_cfg.read_latency;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= dplt_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= known(s_axi_araddr) ? dplt_pkg::RESP_OKAY :
                        dplt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// *** test/dplt_regs_checker.sv ***
// Port checker for the PHY control and line-trap register bank.
// Bound to dplt_regs from the bench; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dplt_regs_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic line_trap_event,
   input wire logic phy_reset_request,
   input wire dplt_pkg::dplt_phy_cfg_t phy_cfg,
   input wire logic irq
);
   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_rst_one_cycle: assert property (
      phy_reset_request |=> !phy_reset_request)
      else $error("PHY reset request wider than one cycle");
   a_rst_by_write: assert property (
      $rose(phy_reset_request) |-> s_axi_bvalid)
      else $error("PHY reset request without a write");
   a_irq_by_trap: assert property (
      $rose(irq) |-> $past(line_trap_event))
      else $error("interrupt rose without a line trap");
   a_irq_by_clear: assert property (
      $fell(irq) |-> s_axi_bvalid)
      else $error("interrupt fell without a write");
   a_trap_keeps_irq: assert property (
      line_trap_event && irq |=> irq)
      else $error("interrupt lost during a line trap");
   a_cfg_by_write: assert property (
      !$stable(phy_cfg) |-> s_axi_bvalid)
      else $error("PHY configuration changed without a write");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench of the register bank over AXI4-Lite.
// Drives every input itself; the checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic trap = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, rst_req, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   dplt_pkg::dplt_phy_cfg_t cfg;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_rst = 0;
   int cycles = 0;
   dplt_regs dplt_regs_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .line_trap_event(trap),
      .phy_reset_request(rst_req), .phy_cfg(cfg), .irq(irq)
   );
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (rst_req === 1'b1) n_rst <= n_rst + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         finish_test();
      end
   end
   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Handshake flags are sampled at the falling edge, where they equal
   // what the next rising edge sees, so no race with the design.
   // The response ready is raised with the request and held until the
   // answer is seen; the write ends on a falling edge so that counters
   // updated at the answering edge have settled before any check.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = dplt_pkg::RESP_OKAY,
      input logic [3:0] s = 4'hF);
      logic ah, wh, bh;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bready && bvalid;
         r = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (bh) bready <= 1'b0;
      end
      @(negedge aclk);
      chk({r, 32'h0}, {er, 32'h0});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = dplt_pkg::RESP_OKAY);
      logic ah, rh;
      logic [33:0] q;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(negedge aclk);
         ah = arvalid && arready;
         rh = rready && rvalid;
         q = {rresp, rdata};
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
         if (rh) rready <= 1'b0;
      end
      chk(q, {er, e});
   endtask
   task automatic pulse();
      @(posedge aclk);
      trap <= 1'b1;
      @(posedge aclk);
      trap <= 1'b0;
      @(negedge aclk);
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, dplt_pkg::PHY_RESET_CONTROL_RST);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0000_0046);
      chk({26'h0, cfg}, 34'h0E);
      wr(8'h00, 32'h0000_2091);
      chk(34'(n_rst), 34'h0);
      wr(8'h00, 32'h0000_2491);
      chk(34'(n_rst), 34'h1);
      pulse();
      chk({33'h0, irq}, 34'h0);
      rd(8'h04, 32'h4);
      rd(8'h08, 32'h0);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h4);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, 32'h4);
      rd(8'h10, 32'h4);
      pulse();
      chk({33'h0, irq}, 34'h1);
      rd(8'h08, 32'h4);
      wr(8'h08, 32'h4);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      chk({33'h0, irq}, 34'h0);
      pulse();
      wr(8'h04, 32'h4);
      rd(8'h08, 32'h0);
      wr(8'h10, 32'h4);
      rd(8'h0C, 32'h0);
      rd(8'h10, 32'h0);
      pulse();
      rd(8'h08, 32'h0);
      chk({33'h0, irq}, 34'h0);
      wr(8'h14, 32'hFFFF_FFFF);
      rd(8'h14, 32'h0000_70C7);
      chk({26'h0, cfg}, 34'hFF);
      wr(8'h14, 32'h0000_2005);
      chk({26'h0, cfg}, 34'h45);
      wr(8'h14, 32'h0000_7007, dplt_pkg::RESP_OKAY, 4'h1);
      chk({26'h0, cfg}, 34'h47);
      wr(8'h40, 32'h4, dplt_pkg::RESP_SLVERR);
      rd(8'h40, 32'h0, dplt_pkg::RESP_SLVERR);
      finish_test();
   end
endmodule
bind dplt_regs dplt_regs_checker dplt_regs_checker_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .line_trap_event(line_trap_event),
   .phy_reset_request(phy_reset_request), .phy_cfg(phy_cfg), .irq(irq)
);
`default_nettype wire
